/* logic/operating_mode_control.sv */
// Operating-mode control: mode tracking, default sizes, limits and privilege decode
//
// Operation
// R1 - After reset the mode is real mode before any other mode.
// R2 - 64-bit submode: default address size 64, operand size 32.
// R3 - 64-bit submode: prefixes override; extension prefix selects 64-bit operands and added registers.
// R4 - 64-bit submode grants upper register halves and extra prefix-reached registers.
// R5 - 64-bit or compatibility submode chosen per code segment.
// R6 - 64-bit submode: flat space, paging required, segmentation largely off.
// R7 - Compatibility submode confines accesses to the lowest 4 Gbytes.
// R8 - Compatibility submode: size prefixes toggle 16/32-bit address and operand size.
// R9 - Compatibility submode uses long-mode translation, interrupt and structure mechanisms.
// R10 - Software enables protected mode before enabling long mode.
// R11 - Real mode never active while long mode operates.
// R12 - Real mode: 1 Mbyte, no paging, operand 16 default, 32 by prefix.
// R13 - Real mode runs everything at privilege level 0.
// R14 - Protected mode: 4 Gbyte spaces, operand size 16 or 32.
// R15 - Protected mode unpaged maps virtual to physical directly; paging optional.
// R16 - Protected mode supports privilege levels 0 through 3.
// R17 - Virtual-machine mode: 1 Mbyte, real translation, operand 16 default, 32 by prefix.
// R18 - Virtual-machine mode entered when the virtual-machine flag is set.
// R19 - Virtual-machine flag changes only on task switch or privileged return, not flag pop.
// R20 - With long mode enabled, entry to virtual-machine mode is silently ignored.
// R21 - Registered current mode drives decoded sizes and privilege range each cycle.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module operating_mode_control (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AXI4-Lite write address
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // AXI4-Lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read address
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // AXI4-Lite read data
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Mode outputs
  output logic [5:0] o_mode,
  output opmode_pkg::mode_attr_s o_attr,
  output logic [1:0] o_eff_addr_size,
  output logic [1:0] o_eff_oper_size,
  output logic o_ext_regs
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Architectural state and decoded next values
  logic prot_en;
  logic page_en;
  logic lme;
  logic cs_long;
  logic cs_dsize;
  logic [1:0] cpl;
  logic virtual_machine_flag;
  logic [3:0] prefix;
  opmode_pkg::op_mode_e mode;
  opmode_pkg::op_mode_e next_mode;
  opmode_pkg::mode_attr_s next_attr;
  logic [1:0] next_eff_addr;
  logic [1:0] next_eff_oper;
  logic next_ext;

  // Bus holding registers
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_hit;
  // Read path
  logic [31:0] rd_word;
  logic rd_hit;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Fires once both halves are held and no answer pends
  assign wr_fire = aw_held && w_held && !o_bvalid;

  // Capture address and data in either order, answer once both are in
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= opmode_pkg::RESP_OKAY;
    end else begin
      // Readies drop after a take and while an answer pends
      o_awready <= !aw_held && !(i_awvalid && o_awready) && !o_bvalid;
      o_wready <= !w_held && !(i_wvalid && o_wready) && !o_bvalid;
      // Address phase
      if (i_awvalid && o_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
      end
      // Data phase
      if (i_wvalid && o_wready) begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      // Both halves in: answer and free the holders
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_hit ? opmode_pkg::RESP_OKAY : opmode_pkg::RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        // Answer stands until bready
        o_bvalid <= 1'b0;
      end
    end
  end

  // Writable addresses
  always_comb begin
    case (aw_addr)
      opmode_pkg::CTRL_ADDR, opmode_pkg::CSEG_ADDR, opmode_pkg::FLAGS_ADDR, opmode_pkg::PREFIX_ADDR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Control and segment registers
  // ----------------------------------------------------------------
  // Control bits; long mode needs protection and paging set in the same write
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      prot_en <= opmode_pkg::CTRL_RESET[opmode_pkg::CTRL_PROT_BIT];
      page_en <= opmode_pkg::CTRL_RESET[opmode_pkg::CTRL_PAGE_BIT];
      lme <= opmode_pkg::CTRL_RESET[opmode_pkg::CTRL_LME_BIT];
    end else if (wr_fire && aw_addr == opmode_pkg::CTRL_ADDR && w_strb[0]) begin
      // Protect holds while long mode stays requested
      prot_en <= w_data[opmode_pkg::CTRL_PROT_BIT] | (lme & w_data[opmode_pkg::CTRL_LME_BIT]); // R11
      // Paging follows the write
      page_en <= w_data[opmode_pkg::CTRL_PAGE_BIT];
      // Long mode activates only over paged protected mode; else the request is dropped
      lme <= w_data[opmode_pkg::CTRL_LME_BIT] & w_data[opmode_pkg::CTRL_PROT_BIT]
             & w_data[opmode_pkg::CTRL_PAGE_BIT]; // R10 R11
    end
  end

  // Code-segment attributes select the long submode per segment
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_long <= 1'b0;
      cs_dsize <= 1'b0;
      cpl <= opmode_pkg::CPL_RESET;
    end else if (wr_fire && aw_addr == opmode_pkg::CSEG_ADDR && w_strb[0]) begin
      cs_long <= w_data[opmode_pkg::CSEG_LONG_BIT]; // R5
      cs_dsize <= w_data[opmode_pkg::CSEG_DSIZE_BIT];
      // Privilege of the running segment
      cpl <= w_data[opmode_pkg::CSEG_CPL_LSB +: 2];
    end
  end

  // Virtual-machine flag: only task switch or privileged return may change it, and long mode clears it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      virtual_machine_flag <= 1'b0;
    end else if (lme) begin
      // Entry attempts are dropped, no error
      virtual_machine_flag <= 1'b0; // R20
    end else if (wr_fire && aw_addr == opmode_pkg::FLAGS_ADDR && w_strb[2] && w_strb[3]) begin
      // Only tagged sources may move the flag
      case (w_data[opmode_pkg::FLAGS_SRC_LSB +: 2])
        opmode_pkg::SRC_TASK_SWITCH: virtual_machine_flag <= w_data[opmode_pkg::FLAGS_VM_BIT] & prot_en; // R19
        opmode_pkg::SRC_INT_RETURN: begin
          if (cpl == opmode_pkg::CPL_RESET) begin
            virtual_machine_flag <= w_data[opmode_pkg::FLAGS_VM_BIT] & prot_en; // R19
          end
        end
        // Flag pop leaves it alone
        default: virtual_machine_flag <= virtual_machine_flag; // R19
      endcase
    end
  end

  // Per-instruction prefix presence
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      prefix <= 4'h0;
    end else if (wr_fire && aw_addr == opmode_pkg::PREFIX_ADDR && w_strb[0]) begin
      // Presence bits for the next instruction
      prefix <= w_data[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  // Next mode from the control state
  always_comb begin
    next_mode = opmode_pkg::MODE_REAL;
    // Otherwise real mode
    if (lme && prot_en) begin
      // Long mode: submode from the code segment
      next_mode = cs_long ? opmode_pkg::MODE_LONG64 : opmode_pkg::MODE_COMPAT; // R5 R11
    end else if (prot_en && virtual_machine_flag && !lme) begin
      // Flag set over protection, long mode off
      next_mode = opmode_pkg::MODE_V86; // R18 R20
    end else if (prot_en) begin
      // Plain protection, paged or not
      next_mode = page_en ? opmode_pkg::MODE_PROT_PAGED : opmode_pkg::MODE_PROT; // R15
    end
  end

  // Registered mode, real mode out of reset
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= opmode_pkg::MODE_REAL; // R1
    end else begin
      mode <= next_mode; // R21
    end
  end

  // ----------------------------------------------------------------
  // Attribute decode
  // ----------------------------------------------------------------
  // Attributes and effective sizes of the registered mode
  always_comb begin
    next_attr = '0;
    next_eff_addr = opmode_pkg::SIZE_16;
    next_eff_oper = opmode_pkg::SIZE_16;
    next_ext = 1'b0;
    case (mode)
      // Real: 1 Mbyte, privilege 0 only
      opmode_pkg::MODE_REAL: begin
        next_attr.space = opmode_pkg::SPACE_1M; // R12
        next_attr.pl_max = 2'h0; // R13
        next_eff_oper = prefix[opmode_pkg::PFX_OPSIZE_BIT] ? opmode_pkg::SIZE_32 : opmode_pkg::SIZE_16; // R12
        next_eff_addr = prefix[opmode_pkg::PFX_ADSIZE_BIT] ? opmode_pkg::SIZE_32 : opmode_pkg::SIZE_16;
      end
      // Virtual machine: fixed at privilege 3
      opmode_pkg::MODE_V86: begin
        next_attr.space = opmode_pkg::SPACE_1M; // R17
        next_attr.pl_min = opmode_pkg::PL_MAX;
        next_attr.pl_max = opmode_pkg::PL_MAX;
        next_attr.paging = page_en;
        next_eff_oper = prefix[opmode_pkg::PFX_OPSIZE_BIT] ? opmode_pkg::SIZE_32 : opmode_pkg::SIZE_16; // R17
        next_eff_addr = prefix[opmode_pkg::PFX_ADSIZE_BIT] ? opmode_pkg::SIZE_32 : opmode_pkg::SIZE_16;
      end
      // Segment sizes, toggled by prefixes
      opmode_pkg::MODE_PROT, opmode_pkg::MODE_PROT_PAGED, opmode_pkg::MODE_COMPAT: begin
        next_attr.addr_size = cs_dsize ? opmode_pkg::SIZE_32 : opmode_pkg::SIZE_16; // R14
        next_attr.oper_size = cs_dsize ? opmode_pkg::SIZE_32 : opmode_pkg::SIZE_16;
        next_attr.space = opmode_pkg::SPACE_4G; // R7 R14
        next_attr.pl_max = opmode_pkg::PL_MAX; // R16
        next_attr.paging = (mode != opmode_pkg::MODE_PROT); // R15
        next_attr.long_mech = (mode == opmode_pkg::MODE_COMPAT); // R9
        next_eff_oper = (cs_dsize ^ prefix[opmode_pkg::PFX_OPSIZE_BIT]) ? opmode_pkg::SIZE_32
                        : opmode_pkg::SIZE_16; // R8
        next_eff_addr = (cs_dsize ^ prefix[opmode_pkg::PFX_ADSIZE_BIT]) ? opmode_pkg::SIZE_32
                        : opmode_pkg::SIZE_16; // R8
      end
      // 64-bit: flat, paged, wide registers
      opmode_pkg::MODE_LONG64: begin
        next_attr.addr_size = opmode_pkg::SIZE_64; // R2
        next_attr.oper_size = opmode_pkg::SIZE_32; // R2
        next_attr.space = opmode_pkg::SPACE_FULL;
        next_attr.pl_max = opmode_pkg::PL_MAX;
        next_attr.reg_ext = 1'b1; // R4
        next_attr.paging = 1'b1; // R6
        next_attr.flat = 1'b1; // R6
        next_attr.long_mech = 1'b1;
        next_eff_addr = prefix[opmode_pkg::PFX_ADSIZE_BIT] ? opmode_pkg::SIZE_32 : opmode_pkg::SIZE_64; // R3
        // Extension W outranks the operand-size prefix
        if (prefix[opmode_pkg::PFX_EXT_BIT] && prefix[opmode_pkg::PFX_EXT_W_BIT]) begin
          next_eff_oper = opmode_pkg::SIZE_64; // R3
        end else begin
          next_eff_oper = prefix[opmode_pkg::PFX_OPSIZE_BIT] ? opmode_pkg::SIZE_16 : opmode_pkg::SIZE_32; // R3
        end
        next_ext = prefix[opmode_pkg::PFX_EXT_BIT]; // R3 R4
      end
      // Unreachable for a one-hot mode
      default: begin
        next_attr = '0;
      end
    endcase
  end

  // Registered mode outputs
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= opmode_pkg::MODE_REAL;
      o_attr <= '0;
      o_eff_addr_size <= opmode_pkg::SIZE_16;
      o_eff_oper_size <= opmode_pkg::SIZE_16;
      o_ext_regs <= 1'b0;
    end else begin
      o_mode <= mode; // R21
      o_attr <= next_attr; // R21
      // Sizes after prefixes
      o_eff_addr_size <= next_eff_addr;
      o_eff_oper_size <= next_eff_oper;
      o_ext_regs <= next_ext;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (i_araddr)
      opmode_pkg::CTRL_ADDR: begin
        rd_word[opmode_pkg::CTRL_PROT_BIT] = prot_en;
        rd_word[opmode_pkg::CTRL_PAGE_BIT] = page_en;
        rd_word[opmode_pkg::CTRL_LME_BIT] = lme;
      end
      opmode_pkg::CSEG_ADDR: begin
        rd_word[opmode_pkg::CSEG_LONG_BIT] = cs_long;
        rd_word[opmode_pkg::CSEG_DSIZE_BIT] = cs_dsize;
        rd_word[opmode_pkg::CSEG_CPL_LSB +: 2] = cpl;
      end
      opmode_pkg::FLAGS_ADDR: rd_word[opmode_pkg::FLAGS_VM_BIT] = virtual_machine_flag;
      opmode_pkg::MODE_ADDR: rd_word[5:0] = o_mode;
      opmode_pkg::ATTR_ADDR: rd_word[13:0] = o_attr;
      opmode_pkg::PREFIX_ADDR: rd_word[3:0] = prefix;
      opmode_pkg::EFF_ADDR: rd_word[4:0] = {o_ext_regs, o_eff_oper_size, o_eff_addr_size};
      // Unmapped: zero data, error answer
      default: rd_hit = 1'b0;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= opmode_pkg::RESP_OKAY;
    end else begin
      // Ready drops after a take and while an answer pends
      o_arready <= !o_rvalid && !(i_arvalid && o_arready);
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= rd_hit ? opmode_pkg::RESP_OKAY : opmode_pkg::RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        // Answer stands until rready
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* pkg/opmode_pkg.sv */
// Package for the operating-mode control block: register map, fields, modes and size codes
package opmode_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;    // Control: protection, paging, long-mode enable
  localparam logic [7:0] CSEG_ADDR = 8'h04;    // Code-segment attributes: long bit, default-size bit, privilege
  localparam logic [7:0] FLAGS_ADDR = 8'h08;   // Flags register write/update port
  localparam logic [7:0] MODE_ADDR = 8'h0C;    // Mode status, read only
  localparam logic [7:0] ATTR_ADDR = 8'h10;    // Decoded attributes, read only
  localparam logic [7:0] PREFIX_ADDR = 8'h14;  // Per-instruction prefix presence
  localparam logic [7:0] EFF_ADDR = 8'h18;     // Effective sizes after prefixes, read only

  // Control fields
  localparam int CTRL_PROT_BIT = 0;
  localparam int CTRL_PAGE_BIT = 1;
  localparam int CTRL_LME_BIT = 2;

  // Code-segment fields
  localparam int CSEG_LONG_BIT = 0;
  localparam int CSEG_DSIZE_BIT = 1;
  localparam int CSEG_CPL_LSB = 4;

  // Flags register write fields
  localparam int FLAGS_VM_BIT = 17;           // Position of the virtual-machine flag
  localparam int FLAGS_SRC_LSB = 24;          // Source of the update, 2 bits

  // Flags update sources
  localparam logic [1:0] SRC_FLAG_POP = 2'h0;
  localparam logic [1:0] SRC_TASK_SWITCH = 2'h1;
  localparam logic [1:0] SRC_INT_RETURN = 2'h2;

  // Prefix fields
  localparam int PFX_OPSIZE_BIT = 0;
  localparam int PFX_ADSIZE_BIT = 1;
  localparam int PFX_EXT_W_BIT = 2;
  localparam int PFX_EXT_BIT = 3;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] CPL_RESET = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Size codes
  localparam logic [1:0] SIZE_16 = 2'h0;
  localparam logic [1:0] SIZE_32 = 2'h1;
  localparam logic [1:0] SIZE_64 = 2'h2;

  // Address-space limit codes: 1 Mbyte, 4 Gbytes, full 64-bit
  localparam logic [1:0] SPACE_1M = 2'h0;
  localparam logic [1:0] SPACE_4G = 2'h1;
  localparam logic [1:0] SPACE_FULL = 2'h2;

  localparam logic [1:0] PL_MAX = 2'h3;

  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_REAL = 6'b000001,
    MODE_PROT = 6'b000010,
    MODE_PROT_PAGED = 6'b000100,
    MODE_V86 = 6'b001000,
    MODE_LONG64 = 6'b010000,
    MODE_COMPAT = 6'b100000
  } op_mode_e;

  // Decoded mode attributes
  typedef struct packed {
    logic [1:0] addr_size;
    logic [1:0] oper_size;
    logic [1:0] space;
    logic [1:0] pl_min;
    logic [1:0] pl_max;
    logic reg_ext;
    logic paging;
    logic flat;
    logic long_mech;
  } mode_attr_s;

endpackage

/* verif/opmode_monitor.sv */
// Checker for the operating-mode control block outputs
`timescale 1ns/1ps
module opmode_monitor (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Mode outputs
  input wire logic [5:0] o_mode,
  input wire opmode_pkg::mode_attr_s o_attr,
  input wire logic [1:0] o_eff_addr_size,
  input wire logic [1:0] o_eff_oper_size,
  input wire logic o_ext_regs
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Mode and attributes register on the same edge; each attribute check waits for the mode held two cycles
  reset_real_a: assert property ($fell(i_rst) |-> o_mode == opmode_pkg::MODE_REAL)
    else $error("mode not real after reset");
  mode_onehot_a: assert property ($onehot(o_mode))
    else $error("mode not one-hot");
  real_attr_a: assert property ((o_mode == opmode_pkg::MODE_REAL) [*2] |-> o_attr == 14'h0000)
    else $error("real mode attributes wrong");
  long_attr_a: assert property ((o_mode == opmode_pkg::MODE_LONG64) [*2] |->
    o_attr.addr_size == opmode_pkg::SIZE_64 && o_attr.oper_size == opmode_pkg::SIZE_32 &&
    o_attr.reg_ext && o_attr.flat && o_attr.paging) else $error("64-bit attributes wrong");
  compat_attr_a: assert property ((o_mode == opmode_pkg::MODE_COMPAT) [*2] |->
    o_attr.space == opmode_pkg::SPACE_4G && o_attr.long_mech && !o_attr.reg_ext)
    else $error("compatibility attributes wrong");
  prot_attr_a: assert property (
    (o_mode == opmode_pkg::MODE_PROT || o_mode == opmode_pkg::MODE_PROT_PAGED) [*2] |->
    o_attr.pl_min == 2'h0 && o_attr.pl_max == opmode_pkg::PL_MAX && o_attr.space == opmode_pkg::SPACE_4G)
    else $error("protected attributes wrong");
  v86_attr_a: assert property ((o_mode == opmode_pkg::MODE_V86) [*2] |->
    o_attr.pl_min == opmode_pkg::PL_MAX && o_attr.space == opmode_pkg::SPACE_1M &&
    o_attr.oper_size == opmode_pkg::SIZE_16) else $error("v86 attributes wrong");
  compat_eff_a: assert property (o_mode == opmode_pkg::MODE_COMPAT |->
    o_eff_addr_size != opmode_pkg::SIZE_64 && o_eff_oper_size != opmode_pkg::SIZE_64)
    else $error("compatibility size out of range");
  ext_regs_a: assert property (o_ext_regs |-> o_mode == opmode_pkg::MODE_LONG64)
    else $error("extension registers outside 64-bit mode");
  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  // Main modes reached
  cover property (o_mode == opmode_pkg::MODE_V86);
  cover property (o_mode == opmode_pkg::MODE_LONG64);
  cover property (o_mode == opmode_pkg::MODE_COMPAT && o_ext_regs == 1'b0);
endmodule

/* verif/testbench.sv */
// Testbench for the operating-mode control block
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_ext_regs;
  logic [1:0] o_bresp, o_rresp, o_eff_addr_size, o_eff_oper_size, resp;
  logic [31:0] o_rdata, data;
  logic [5:0] o_mode;
  opmode_pkg::mode_attr_s o_attr;
  int bad_count = 0;
  int checks = 0;

  // Device under test
  operating_mode_control u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_mode(o_mode), .o_attr(o_attr), .o_eff_addr_size(o_eff_addr_size),
    .o_eff_oper_size(o_eff_oper_size), .o_ext_regs(o_ext_regs));

  // Clock of 25 ns
  always #12.5 i_sys_clk = ~i_sys_clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus write or read, then time for the mode outputs to settle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    if (w) begin
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
    end else begin
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
    end
    do begin
      @(posedge i_sys_clk);
      n++;
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (n > 50) begin
        bad_count++;
        $display("BAD t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        results();
      end
    end while (!(w ? o_bvalid : o_rvalid));
    resp = w ? o_bresp : o_rresp;
    data = o_rdata;
    i_bready <= 1'b0;
    i_rready <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask

  // Packed attribute expectation
  function automatic logic [13:0] attr_of(input logic [1:0] a, o, s, lo, hi, input logic [3:0] f);
    return {a, o, s, lo, hi, f};
  endfunction

  // Mode and attributes together
  task automatic mchk(input logic [5:0] m, input logic [13:0] a);
    chk(o_mode, m);
    chk(o_attr, a);
  endtask

  // Prefix write and effective sizes
  task automatic pchk(input logic [3:0] p, input logic [1:0] a, o, input logic x);
    xfer(1'b1, opmode_pkg::PREFIX_ADDR, {28'h0, p});
    chk({o_ext_regs, o_eff_addr_size, o_eff_oper_size}, {x, a, o});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset state, long enable refused without protection, size prefix
  task automatic t_real;
    logic [13:0] ra;
    ra = attr_of(opmode_pkg::SIZE_16, opmode_pkg::SIZE_16, opmode_pkg::SPACE_1M, 2'h0, 2'h0, 4'h0);
    mchk(opmode_pkg::MODE_REAL, ra);
    xfer(1'b1, opmode_pkg::CTRL_ADDR, 32'h0000_0004);
    mchk(opmode_pkg::MODE_REAL, ra);
    pchk(4'h1, opmode_pkg::SIZE_16, opmode_pkg::SIZE_32, 1'b0);
    $display("real mode test done");
  endtask

  // Protected unpaged and paged
  task automatic t_prot;
    xfer(1'b1, opmode_pkg::CSEG_ADDR, 32'h0000_0002);
    xfer(1'b1, opmode_pkg::CTRL_ADDR, 32'h0000_0001);
    mchk(opmode_pkg::MODE_PROT, attr_of(2'h1, 2'h1, 2'h1, 2'h0, 2'h3, 4'h0));
    pchk(4'h3, opmode_pkg::SIZE_16, opmode_pkg::SIZE_16, 1'b0);
    pchk(4'h0, opmode_pkg::SIZE_32, opmode_pkg::SIZE_32, 1'b0);
    xfer(1'b1, opmode_pkg::CTRL_ADDR, 32'h0000_0003);
    mchk(opmode_pkg::MODE_PROT_PAGED, attr_of(2'h1, 2'h1, 2'h1, 2'h0, 2'h3, 4'h4));
    xfer(1'b1, opmode_pkg::CTRL_ADDR, 32'h0000_0001);
    $display("protected mode test done");
  endtask

  // Virtual-machine flag sources
  task automatic t_v86;
    xfer(1'b1, opmode_pkg::FLAGS_ADDR, 32'h0002_0000);
    chk(o_mode, opmode_pkg::MODE_PROT);
    xfer(1'b1, opmode_pkg::FLAGS_ADDR, 32'h0102_0000);
    mchk(opmode_pkg::MODE_V86, attr_of(2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 4'h0));
    xfer(1'b1, opmode_pkg::FLAGS_ADDR, 32'h0000_0000);
    chk(o_mode, opmode_pkg::MODE_V86);
    xfer(1'b1, opmode_pkg::FLAGS_ADDR, 32'h0100_0000);
    chk(o_mode, opmode_pkg::MODE_PROT);
    xfer(1'b1, opmode_pkg::FLAGS_ADDR, 32'h0202_0000);
    chk(o_mode, opmode_pkg::MODE_V86);
    xfer(1'b1, opmode_pkg::FLAGS_ADDR, 32'h0100_0000);
    $display("v86 mode test done");
  endtask

  // Long mode submodes, prefixes, refused v86 entry and refused real mode
  task automatic t_long;
    xfer(1'b1, opmode_pkg::CSEG_ADDR, 32'h0000_0001);
    xfer(1'b1, opmode_pkg::CTRL_ADDR, 32'h0000_0007);
    mchk(opmode_pkg::MODE_LONG64, attr_of(2'h2, 2'h1, 2'h2, 2'h0, 2'h3, 4'hF));
    pchk(4'hC, opmode_pkg::SIZE_64, opmode_pkg::SIZE_64, 1'b1);
    pchk(4'h1, opmode_pkg::SIZE_64, opmode_pkg::SIZE_16, 1'b0);
    pchk(4'h2, opmode_pkg::SIZE_32, opmode_pkg::SIZE_32, 1'b0);
    pchk(4'h0, opmode_pkg::SIZE_64, opmode_pkg::SIZE_32, 1'b0);
    xfer(1'b1, opmode_pkg::CSEG_ADDR, 32'h0000_0002);
    mchk(opmode_pkg::MODE_COMPAT, attr_of(2'h1, 2'h1, 2'h1, 2'h0, 2'h3, 4'h5));
    pchk(4'hB, opmode_pkg::SIZE_16, opmode_pkg::SIZE_16, 1'b0);
    pchk(4'h0, opmode_pkg::SIZE_32, opmode_pkg::SIZE_32, 1'b0);
    xfer(1'b1, opmode_pkg::FLAGS_ADDR, 32'h0102_0000);
    chk(o_mode, opmode_pkg::MODE_COMPAT);
    chk(resp, opmode_pkg::RESP_OKAY);
    xfer(1'b1, opmode_pkg::CTRL_ADDR, 32'h0000_0006);
    chk(o_mode, opmode_pkg::MODE_PROT_PAGED);
    xfer(1'b0, opmode_pkg::CTRL_ADDR, 32'h0);
    chk(data, 32'h0000_0003);
    $display("long mode test done");
  endtask

  // Unmapped place on the register bus
  task automatic t_bus;
    xfer(1'b0, 8'hFC, 32'h0);
    chk(resp, opmode_pkg::RESP_SLVERR);
    chk(data, 32'h0);
    xfer(1'b1, 8'hFC, 32'hFFFF_FFFF);
    chk(resp, opmode_pkg::RESP_SLVERR);
    $display("bus test done");
  endtask

  // ----------------------------------------------------------------
  // Main
  // ----------------------------------------------------------------
  // Reset, scenarios, verdict
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_real();
    t_prot();
    t_v86();
    t_long();
    t_bus();
    results();
  end
endmodule

// Checker attached to the design
bind operating_mode_control opmode_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_mode(o_mode),
  .o_attr(o_attr), .o_eff_addr_size(o_eff_addr_size), .o_eff_oper_size(o_eff_oper_size), .o_ext_regs(o_ext_regs));
